// [hw/wss_pkg.sv]
// Overview of operation
// - delay-select one: slot value is an idle time of 10 ms per count, no waveform.
// - delay-select zero: slot value is an effect index into the waveform library.
// - playback trigger asserted: sequencing starts at the first slot, address 0x0F.
// - after one slot finishes, advance to the next slot if its entry is non-zero.
// - sequence ends after the eighth slot, address sequence_slot_eight, has been played.
// - a zero entry stops playback there; nothing is played for it.
// - slot byte: delay-select in bit 7, index or count in bits 6-0, RW, reset zero.
package wss_pkg;
  localparam logic [7:0] WSS_TRIGGER_ADDR = 8'h0c;
  localparam logic [7:0] WSS_FIRST_SLOT_ADDR = 8'h0f;
  localparam logic [7:0] WSS_SLOT7_ADDR = 8'h15;
  localparam logic [7:0] WSS_SLOT8_ADDR = 8'h16;
  localparam logic [7:0] WSS_SLOT_RESET = 8'h00;
  localparam logic [7:0] WSS_UNMAPPED_READ = 8'h00;
  localparam int WSS_DELAY_SEL_BIT = 7;
  localparam int WSS_VALUE_MSB = 6;
  localparam int WSS_VALUE_W = 7;
  localparam int WSS_NUM_SLOTS = 8;
  localparam int WSS_IDX_W = 3;
  localparam logic [2:0] WSS_FIRST_IDX = 3'h0;
  localparam logic [2:0] WSS_SLOT7_IDX = 3'h6;
  localparam logic [2:0] WSS_LAST_IDX = 3'h7;
  localparam logic [7:0] WSS_STOP_ENTRY = 8'h00;
  // delay step and clock rate
  localparam int WSS_STEP_MS = 10;
  localparam int WSS_CLK_KHZ = 250000;
  localparam int WSS_TICKS_PER_STEP = WSS_STEP_MS * WSS_CLK_KHZ;
  typedef enum logic [1:0] {WSS_IDLE, WSS_DECODE, WSS_PLAY, WSS_WAIT} wss_state_t;
endpackage

// [hw/wss_sequencer.sv]
`timescale 1ns/1ps
module wss_sequencer #(
  parameter int TICKS_PER_STEP = wss_pkg::WSS_TICKS_PER_STEP
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData_r,
  input wire logic playTrigger,
  output logic [2:0] slotReadIdx_r,
  input wire logic [7:0] lowerSlotData,
  input wire logic effectDone,
  output logic effectStart_r,
  output logic [6:0] effectIndex_r,
  output logic idleActive_r,
  output logic busy_r
);
  localparam int IDLE_MAX = 2;

  initial begin
    if (TICKS_PER_STEP < 2) begin
      $error("ticks per step must be at least two");
    end
  end

  logic [7:0] slot7_r;
  logic [7:0] slot8_r;
  logic trigPrev_r;
  logic trigRise;
  logic [7:0] entry;
  wss_pkg::wss_state_t state_r;
  wss_timer_if tmr ();

  wss_step_timer #(.TICKS(TICKS_PER_STEP)) u_timer (
    .clk(clk),
    .nrst(nrst),
    .tmr(tmr)
  );

  assign trigRise = playTrigger && !trigPrev_r;

  // current slot: own bytes for slots seven and eight, the rest come from outside
  always_comb begin
    if (slotReadIdx_r == wss_pkg::WSS_SLOT7_IDX) begin
      entry = slot7_r;
    end else if (slotReadIdx_r == wss_pkg::WSS_LAST_IDX) begin
      entry = slot8_r;
    end else begin
      entry = lowerSlotData;
    end
  end

  // slot registers, full byte read/write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      slot7_r <= wss_pkg::WSS_SLOT_RESET;
      slot8_r <= wss_pkg::WSS_SLOT_RESET;
    end else if (regWrEn) begin
      if (regAddr == wss_pkg::WSS_SLOT7_ADDR) begin
        slot7_r <= regWrData;
      end
      if (regAddr == wss_pkg::WSS_SLOT8_ADDR) begin
        slot8_r <= regWrData;
      end
    end
  end

  // registered read data, answered one edge after the read strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regRdData_r <= wss_pkg::WSS_UNMAPPED_READ;
    end else if (regRdEn) begin
      if (regAddr == wss_pkg::WSS_SLOT7_ADDR) begin
        regRdData_r <= slot7_r;
      end else if (regAddr == wss_pkg::WSS_SLOT8_ADDR) begin
        regRdData_r <= slot8_r;
      end else begin
        regRdData_r <= wss_pkg::WSS_UNMAPPED_READ;
      end
    end
  end

  // trigger edge; a held trigger starts only one pass
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      trigPrev_r <= 1'b0;
    end else begin
      trigPrev_r <= playTrigger;
    end
  end

  // the sequencer walks slots in order; a new trigger while busy is ignored
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= wss_pkg::WSS_IDLE;
      busy_r <= 1'b0;
      slotReadIdx_r <= wss_pkg::WSS_FIRST_IDX;
    end else begin
      case (state_r)
        wss_pkg::WSS_IDLE: begin
          if (trigRise) begin
            state_r <= wss_pkg::WSS_DECODE;
            busy_r <= 1'b1;
            slotReadIdx_r <= wss_pkg::WSS_FIRST_IDX;
          end
        end
        wss_pkg::WSS_DECODE: begin
          if (entry == wss_pkg::WSS_STOP_ENTRY) begin
            state_r <= wss_pkg::WSS_IDLE;
            busy_r <= 1'b0;
          end else if (entry[wss_pkg::WSS_DELAY_SEL_BIT]) begin
            state_r <= wss_pkg::WSS_WAIT;
          end else begin
            state_r <= wss_pkg::WSS_PLAY;
          end
        end
        wss_pkg::WSS_PLAY, wss_pkg::WSS_WAIT: begin
          if ((state_r == wss_pkg::WSS_PLAY && effectDone) || (state_r == wss_pkg::WSS_WAIT && tmr.done)) begin
            if (slotReadIdx_r == wss_pkg::WSS_LAST_IDX) begin
              state_r <= wss_pkg::WSS_IDLE;
              busy_r <= 1'b0;
            end else begin
              state_r <= wss_pkg::WSS_DECODE;
              slotReadIdx_r <= slotReadIdx_r + 3'h1;
            end
          end
        end
        default: begin
          state_r <= wss_pkg::WSS_IDLE;
          busy_r <= 1'b0;
        end
      endcase
    end
  end

  // effect start pulse and index to the library player
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      effectStart_r <= 1'b0;
      effectIndex_r <= '0;
    end else if (state_r == wss_pkg::WSS_DECODE && entry != wss_pkg::WSS_STOP_ENTRY &&
                 !entry[wss_pkg::WSS_DELAY_SEL_BIT]) begin
      effectStart_r <= 1'b1;
      effectIndex_r <= entry[wss_pkg::WSS_VALUE_MSB:0];
    end else begin
      effectStart_r <= 1'b0;
    end
  end

  // idle request to the step timer; idle flag stands through the wait
  always_comb begin
    tmr.start = (state_r == wss_pkg::WSS_DECODE) && entry[wss_pkg::WSS_DELAY_SEL_BIT];
    tmr.steps = entry[wss_pkg::WSS_VALUE_MSB:0];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      idleActive_r <= 1'b0;
    end else if (tmr.start) begin
      idleActive_r <= 1'b1;
    end else if (tmr.done) begin
      idleActive_r <= 1'b0;
    end
  end

  AST_ZERO_STOPS: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == wss_pkg::WSS_DECODE && entry == 8'h00) |=> (state_r == wss_pkg::WSS_IDLE && !busy_r && !effectStart_r))
    else $error("zero entry did not stop playback");
  AST_EFFECT_INDEX: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == wss_pkg::WSS_DECODE && entry != 8'h00 && !entry[7]) |=>
    (effectStart_r && effectIndex_r == $past(entry[6:0]) && state_r == wss_pkg::WSS_PLAY))
    else $error("effect index not issued from slot");
  AST_DELAY_NO_WAVE: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == wss_pkg::WSS_DECODE && entry[7]) |=> (idleActive_r && !effectStart_r) [*2])
    else $error("delay slot produced a waveform");
  AST_START_FIRST: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == wss_pkg::WSS_IDLE && trigRise) |=> (slotReadIdx_r == 3'h0 && state_r == wss_pkg::WSS_DECODE && busy_r))
    else $error("playback did not start at first slot");
  AST_ADVANCE: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == wss_pkg::WSS_PLAY && effectDone && slotReadIdx_r != 3'h7) |=>
    (state_r == wss_pkg::WSS_DECODE && slotReadIdx_r == $past(slotReadIdx_r) + 3'h1))
    else $error("sequencer did not advance to next slot");
  // only the finish event of the current state counts; a stray effect done during a wait must not end the pass
  AST_END_LAST: assert property (@(posedge clk) disable iff (!nrst)
    (slotReadIdx_r == wss_pkg::WSS_LAST_IDX &&
     ((state_r == wss_pkg::WSS_PLAY && effectDone) || (state_r == wss_pkg::WSS_WAIT && tmr.done))) |=>
    (state_r == wss_pkg::WSS_IDLE && !busy_r))
    else $error("sequence did not end after last slot");
  AST_READBACK: assert property (@(posedge clk) disable iff (!nrst)
    (regWrEn && regAddr == 8'h15 ##1 regRdEn && regAddr == 8'h15 && !regWrEn) |=>
    regRdData_r == $past(regWrData, 2))
    else $error("slot seven readback mismatch");
  AST_ZERO_DELAY_BOUND: assert property (@(posedge clk) disable iff (!nrst)
    (tmr.start && tmr.steps == 7'h00) |-> ##[1:IDLE_MAX] tmr.done)
    else $error("zero-length delay did not finish promptly");

  // a delay slot keeps the idle flag up and starts nothing for its whole length
  AST_WAIT_NO_EFFECT: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == wss_pkg::WSS_WAIT) |-> (idleActive_r && !effectStart_r))
    else $error("waveform started during a delay slot");
  AST_IDLE_CLEARS: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == wss_pkg::WSS_WAIT && tmr.done) |=> !idleActive_r)
    else $error("idle flag stayed up after the delay ended");
  // the index must stand while an effect plays, so the slot is read only when reached
  AST_IDX_HELD: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == wss_pkg::WSS_PLAY && !effectDone) |=> (slotReadIdx_r == $past(slotReadIdx_r)))
    else $error("slot index moved while an effect was playing");
  AST_BUSY_STATE: assert property (@(posedge clk) disable iff (!nrst)
    busy_r == (state_r != wss_pkg::WSS_IDLE))
    else $error("busy flag disagrees with sequencer state");

  COV_EFFECT: cover property (@(posedge clk) disable iff (!nrst) effectStart_r);
  COV_DELAY: cover property (@(posedge clk) disable iff (!nrst) $rose(idleActive_r));
  COV_LAST_SLOT: cover property (@(posedge clk) disable iff (!nrst)
    slotReadIdx_r == 3'h7 && state_r == wss_pkg::WSS_PLAY);
  COV_ZERO_STOP: cover property (@(posedge clk) disable iff (!nrst)
    state_r == wss_pkg::WSS_DECODE && entry == 8'h00 && slotReadIdx_r != 3'h0);
  COV_ZERO_DELAY: cover property (@(posedge clk) disable iff (!nrst)
    tmr.start && tmr.steps == 7'h00);
endmodule

// [hw/wss_step_timer.sv]
`timescale 1ns/1ps
module wss_step_timer #(
  parameter int TICKS = wss_pkg::WSS_TICKS_PER_STEP
) (
  input wire logic clk,
  input wire logic nrst,
  wss_timer_if.timer tmr
);
  localparam int TW = (TICKS < 2) ? 1 : $clog2(TICKS);

  initial begin
    if (TICKS < 2) begin
      $error("step timer needs at least two ticks per step");
    end
  end

  logic [TW-1:0] tickCnt_r;
  logic [6:0] stepsLeft_r;
  logic running_r;
  logic done_r;

  assign tmr.done = done_r;

  // counts whole steps of clock ticks; a zero count finishes on the next edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tickCnt_r <= '0;
      stepsLeft_r <= '0;
      running_r <= 1'b0;
      done_r <= 1'b0;
    end else if (tmr.start) begin
      tickCnt_r <= '0;
      stepsLeft_r <= tmr.steps;
      running_r <= 1'b1;
      done_r <= 1'b0;
    end else if (running_r) begin
      if (stepsLeft_r == 7'h00) begin
        running_r <= 1'b0;
        done_r <= 1'b1;
      end else if (tickCnt_r == TW'(TICKS - 1)) begin
        tickCnt_r <= '0;
        stepsLeft_r <= stepsLeft_r - 7'h01;
      end else begin
        tickCnt_r <= tickCnt_r + 1'b1;
      end
    end else begin
      done_r <= 1'b0;
    end
  end
endmodule

// [hw/wss_timer_if.sv]
`timescale 1ns/1ps
// carries the idle request from the sequencer to the step timer
interface wss_timer_if;
  logic start;
  logic [6:0] steps;
  logic done;
  modport ctrl (output start, output steps, input done);
  modport timer (input start, input steps, output done);
endinterface

// [verif/tb.sv]
`timescale 1ns/1ps
module tb;
  localparam int TICKS = 4;
  logic clk, nrst, regWrEn, regRdEn, playTrigger, effectDone;
  logic [7:0] regAddr, regWrData, regRdData_r, lowerSlotData, rdVal;
  logic [2:0] slotReadIdx_r;
  logic effectStart_r, idleActive_r, busy_r;
  logic [6:0] effectIndex_r;
  logic [7:0] lower [0:5];
  int errors, n_checks, cycles, starts;

  wss_sequencer #(.TICKS_PER_STEP(TICKS)) u_wss_sequencer (
    .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
    .regRdEn(regRdEn), .regRdData_r(regRdData_r), .playTrigger(playTrigger),
    .slotReadIdx_r(slotReadIdx_r), .lowerSlotData(lowerSlotData), .effectDone(effectDone),
    .effectStart_r(effectStart_r), .effectIndex_r(effectIndex_r), .idleActive_r(idleActive_r),
    .busy_r(busy_r)
  );

  // slots one to six live outside; a stray read of them for slot seven or eight sees a non-zero pattern
  assign lowerSlotData = (slotReadIdx_r < 3'h6) ? lower[slotReadIdx_r] : 8'h5a;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // cycle ceiling well above the four passes; also counts effect starts
  always @(posedge clk) begin
    cycles++;
    if (effectStart_r === 1'b1) starts++;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end

  task test_done;
    if (errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // lets an edge pass first, so two writes in a row never drop and raise the strobe in one step
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk);
    regWrEn = 1'b0;
  endtask

  // read data is sampled a full cycle after the strobe so the registered answer has landed
  task rd(input logic [7:0] a, output logic [7:0] d);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk);
    regRdEn = 1'b0;
    @(negedge clk);
    d = regRdData_r;
  endtask

  task go;
    starts = 0;
    playTrigger = 1'b1;
    @(negedge clk);
    chk({7'h0, busy_r}, 8'h01);
    chk({5'h0, slotReadIdx_r}, 8'h00);
    playTrigger = 1'b0;
  endtask

  // wait for one library effect, then answer with a done pulse two cycles later
  task play(input logic [6:0] idx);
    for (int i = 0; i < 50 && effectStart_r !== 1'b1; i++) @(negedge clk);
    chk({7'h0, effectStart_r}, 8'h01);
    chk({1'b0, effectIndex_r}, {1'b0, idx});
    chk({7'h0, idleActive_r}, 8'h00);
    @(negedge clk);
    @(negedge clk);
    effectDone = 1'b1;
    @(negedge clk);
    effectDone = 1'b0;
  endtask

  // idle slot: length in cycles follows the count, and no effect may start meanwhile
  task idle(input int cnt);
    int n, s0;
    for (int i = 0; i < 50 && idleActive_r !== 1'b1; i++) @(negedge clk);
    n = 0;
    s0 = starts;
    while (idleActive_r === 1'b1 && n < 2000) begin
      n++;
      @(negedge clk);
    end
    chk(8'(n >= cnt * TICKS && n <= cnt * TICKS + 4), 8'h01);
    chk(8'(starts - s0), 8'h00);
  endtask

  task finish_pass(input int nStarts);
    for (int i = 0; i < 50 && busy_r !== 1'b0; i++) @(negedge clk);
    chk({7'h0, busy_r}, 8'h00);
    repeat (4) @(negedge clk);
    chk(8'(starts), 8'(nStarts));
  endtask

  initial begin
    nrst = 1'b0;
    regAddr = 8'h00;
    regWrEn = 1'b0;
    regWrData = 8'h00;
    regRdEn = 1'b0;
    playTrigger = 1'b0;
    effectDone = 1'b0;
    errors = 0;
    n_checks = 0;
    cycles = 0;
    starts = 0;
    lower = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16};
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    // reset values, read-write of 0xa5 in slot seven and 0x5a in slot eight, unmapped read
    rd(wss_pkg::WSS_SLOT7_ADDR, rdVal);
    chk(rdVal, 8'h00);
    rd(wss_pkg::WSS_SLOT8_ADDR, rdVal);
    chk(rdVal, 8'h00);
    wr(wss_pkg::WSS_SLOT7_ADDR, 8'ha5);
    wr(wss_pkg::WSS_SLOT8_ADDR, 8'h5a);
    rd(wss_pkg::WSS_SLOT7_ADDR, rdVal);
    chk(rdVal, 8'ha5);
    rd(wss_pkg::WSS_SLOT8_ADDR, rdVal);
    chk(rdVal, 8'h5a);
    rd(8'h20, rdVal);
    chk(rdVal, 8'h00);
    // pass one: all eight slots, slot seven idles two steps; read straight after the write
    wr(wss_pkg::WSS_SLOT7_ADDR, 8'h82);
    rd(wss_pkg::WSS_SLOT7_ADDR, rdVal);
    chk(rdVal, 8'h82);
    wr(wss_pkg::WSS_SLOT8_ADDR, 8'h33);
    go();
    for (int k = 0; k < 6; k++) play(lower[k][6:0]);
    idle(2);
    play(7'h33);
    finish_pass(7);
    // pass two: slot seven an effect, slot eight idles one step and ends the pass
    wr(wss_pkg::WSS_SLOT7_ADDR, 8'h45);
    wr(wss_pkg::WSS_SLOT8_ADDR, 8'h81);
    go();
    for (int k = 0; k < 6; k++) play(lower[k][6:0]);
    play(7'h45);
    idle(1);
    finish_pass(7);
    // pass three: a zero byte in slot three stops the pass
    lower[2] = 8'h00;
    go();
    play(7'h11);
    play(7'h12);
    finish_pass(2);
    // pass four: a zero-length delay in slot one, then a zero byte in slot two
    lower[0] = 8'h80;
    lower[1] = 8'h00;
    go();
    idle(0);
    finish_pass(0);
    test_done();
  end
endmodule
